// *** src/boost_adaptive_sync_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module boost_adaptive_sync_control (
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Pins from outside the clock domain.
  input  wire logic                 enable_pin,
  input  wire logic                 boost_clock_select_pin,
  input  wire logic [2:0]           string_count_setting_pin,
  input  wire logic [5:0]           headroom_low,
  input  wire logic [5:0]           string_fault,
  input  wire logic                 overvoltage_low_level,
  input  wire logic                 overvoltage_high_level,
  input  wire logic                 undervoltage_level,
  input  wire logic                 supply_uv,
  input  wire logic                 thermal_shutdown,
  // Configuration bits from the host.
  input  wire logic                 bus_enable,
  input  wire logic                 fault_clear,
  input  wire logic                 span_write,
  input  wire logic [1:0]           span_wdata,
  input  wire logic                 dither_rate_write,
  input  wire logic [1:0]           dither_rate_wdata,
  input  wire logic [15:0]          base_period,
  // Boost control outputs.
  output logic                      boost_gate,
  output logic                      sinks_active,
  output logic                      fault_recovery,
  output logic [9:0]                boost_target,
  // Clock status.
  output logic                      ext_sync_mode,
  output logic                      dither_enabled,
  output logic [1:0]                span_field,
  output logic [1:0]                dither_rate_field,
  // Status flags.
  output logic                      boost_overvoltage_low_flag,
  output logic                      boost_overvoltage_high_flag,
  output logic                      boost_overcurrent_flag,
  // Open-drain fault pin.
  output logic                      boost_fault_pin_out,
  output logic                      boost_fault_pin_oe
);

  localparam logic [9:0] ONE10 = 10'h1;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0]                     en_s1;
    logic [1:0]                     sel_s1;
    logic [5:0]                     hr_s1;
    logic [5:0]                     hr_s2;
    logic [5:0]                     sf_s1;
    logic [5:0]                     sf_s2;
    logic [2:0]                     cnt_s1;
    logic [2:0]                     cnt_s2;
    logic [4:0]                     pr_s1;
    logic [4:0]                     pr_s2;
    logic                           en_prev;
    boost_ctrl_pkg::loop_state_t    st;
    logic [9:0]                     target;
    logic [15:0]                    sample_cnt;
    logic [15:0]                    start_cnt;
    logic [22:0]                    uv_cnt;
    logic                           ovl;
    logic                           ovh;
    logic                           ocp;
    logic [1:0]                     span;
    logic [1:0]                     rate;
    logic                           ext;
    logic                           dither;
    logic                           gate;
    logic                           fault_od;
  } core_t;

  core_t s_q, s_d;
  logic  sel_s;
  logic  en_s;
  logic  ext_present;
  logic  sync_rise;
  logic  int_tick;
  logic  [5:0] watched;
  logic  [5:0] lacking;

  // Outputs enabled for a given string count; 0 or above 6 means all.
  function automatic logic [5:0] active_mask(input logic [2:0] n);
    case (n)
      3'h1:    active_mask = 6'h01;
      3'h2:    active_mask = 6'h03;
      3'h3:    active_mask = 6'h07;
      3'h4:    active_mask = 6'h0f;
      3'h5:    active_mask = 6'h1f;
      default: active_mask = 6'h3f;
    endcase
  endfunction

  assign sel_s = s_q.sel_s1[1];
  assign en_s  = s_q.en_s1[1];

  sync_detect u_sync_detect (
    .mclk        (mclk),
    .reset       (reset),
    .pin_s       (sel_s),
    .clk_present (ext_present),
    .rise_pulse  (sync_rise)
  );

  boost_clock_gen u_boost_clock_gen (
    .mclk        (mclk),
    .reset       (reset),
    .base_period (base_period),
    .dither_on   (s_q.dither),
    .span_field  (s_q.span),
    .rate_field  (s_q.rate),
    .tick        (int_tick)
  );

  // Loop considers only enabled and unfaulted strings.
  always_comb begin
    watched = active_mask(s_q.cnt_s2) & ~s_q.sf_s2;
    lacking = watched & s_q.hr_s2;
  end

  // Next state of the whole block.
  always_comb begin
    s_d = s_q;
    // Two-stage synchronisers for every pin input.
    s_d.en_s1   = {s_q.en_s1[0], enable_pin};
    s_d.sel_s1  = {s_q.sel_s1[0], boost_clock_select_pin};
    s_d.hr_s1   = headroom_low;
    s_d.hr_s2   = s_q.hr_s1;
    s_d.sf_s1   = string_fault;
    s_d.sf_s2   = s_q.sf_s1;
    s_d.cnt_s1  = string_count_setting_pin;
    s_d.cnt_s2  = s_q.cnt_s1;
    s_d.pr_s1   = {overvoltage_low_level, overvoltage_high_level,
                   undervoltage_level, supply_uv, thermal_shutdown};
    s_d.pr_s2   = s_q.pr_s1;
    s_d.en_prev = en_s;

    // Spread field writes from the host.
    if (span_write) s_d.span = span_wdata;
    if (dither_rate_write) s_d.rate = dither_rate_wdata;

    // Sync presence is tracked continuously, so start-up and later loss
    // both fall back to the internal clock; spread follows the level.
    s_d.ext    = ext_present;
    s_d.dither = !ext_present && sel_s;

    // Fault clears first, so a same-cycle set below still wins.
    if (fault_clear || (s_q.en_prev && !en_s)) begin
      s_d.ovl = 1'b0;
      s_d.ovh = 1'b0;
      s_d.ocp = 1'b0;
    end

    // Sequencer: soft-start, adaptive run, latched fault recovery.
    case (s_q.st)
      boost_ctrl_pkg::ST_IDLE: begin
        s_d.target = '0;
        s_d.uv_cnt = '0;
        if (en_s) begin
          s_d.target = boost_ctrl_pkg::TARGET_INIT;
          s_d.start_cnt = '0;
          s_d.st = boost_ctrl_pkg::ST_START;
        end
      end
      boost_ctrl_pkg::ST_START: begin
        // Sinks stay off until the start target has had time to settle.
        if (s_q.start_cnt ==
            16'(boost_ctrl_pkg::SOFTSTART_CYC - 1)) begin
          s_d.sample_cnt = '0;
          s_d.st = boost_ctrl_pkg::ST_RUN;
        end else begin
          s_d.start_cnt = s_q.start_cnt + 16'h1;
        end
      end
      boost_ctrl_pkg::ST_RUN: begin
        if (s_q.sample_cnt ==
            16'(boost_ctrl_pkg::SAMPLE_CYC - 1)) begin
          s_d.sample_cnt = '0;
          if (|lacking) begin
            if (s_q.target != boost_ctrl_pkg::TARGET_MAX) begin
              s_d.target = s_q.target + ONE10;
            end
          end else if (|watched && s_q.target != '0) begin
            s_d.target = s_q.target - ONE10;
          end
        end else begin
          s_d.sample_cnt = s_q.sample_cnt + 16'h1;
        end
        // Under-voltage timer; recovery clears it without a flag.
        if (s_q.pr_s2[2]) begin
          if (s_q.uv_cnt ==
              23'(boost_ctrl_pkg::UV_TIMEOUT_CYC - 1)) begin
            s_d.ocp = 1'b1;
            s_d.st = boost_ctrl_pkg::ST_FAULT;
          end else begin
            s_d.uv_cnt = s_q.uv_cnt + 23'h1;
          end
        end else begin
          s_d.uv_cnt = '0;
        end
        if (s_q.pr_s2[3]) begin
          s_d.ovh = 1'b1;
          s_d.st = boost_ctrl_pkg::ST_FAULT;
        end
      end
      boost_ctrl_pkg::ST_FAULT: begin
        // Recovery waits for enable to drop and rise again.
        s_d.uv_cnt = '0;
        if (!en_s) s_d.st = boost_ctrl_pkg::ST_IDLE;
      end
      default: s_d.st = boost_ctrl_pkg::ST_IDLE;
    endcase
    if (!en_s && s_q.st != boost_ctrl_pkg::ST_FAULT) begin
      s_d.st = boost_ctrl_pkg::ST_IDLE;
    end

    // Over-voltage low holds the gate off but keeps the sinks running.
    if (s_q.pr_s2[4] && s_q.st != boost_ctrl_pkg::ST_IDLE) begin
      s_d.ovl = 1'b1;
    end
    s_d.gate = 1'b0;
    if ((s_q.st == boost_ctrl_pkg::ST_START ||
         s_q.st == boost_ctrl_pkg::ST_RUN) && !s_q.pr_s2[4]) begin
      s_d.gate = s_q.ext ? sync_rise : int_tick;
    end

    // Boost fault summary drives the pin low only with the bus off.
    s_d.fault_od = !bus_enable &&
      (s_q.ocp || s_q.ovh || s_q.ovl || s_q.pr_s2[1] || s_q.pr_s2[0]);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= boost_ctrl_pkg::ST_IDLE;
      s_q.span <= boost_ctrl_pkg::SPAN_RESET;
      s_q.rate <= boost_ctrl_pkg::DITHER_RATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs but the constant-low boost_fault_pin_out come straight from registered state.
  assign boost_gate                  = s_q.gate;
  assign sinks_active                = s_q.st[2];
  assign fault_recovery              = s_q.st[3];
  assign boost_target                = s_q.target;
  assign ext_sync_mode               = s_q.ext;
  assign dither_enabled              = s_q.dither;
  assign span_field                  = s_q.span;
  assign dither_rate_field           = s_q.rate;
  assign boost_overvoltage_low_flag  = s_q.ovl;
  assign boost_overvoltage_high_flag = s_q.ovh;
  assign boost_overcurrent_flag      = s_q.ocp;
  assign boost_fault_pin_out         = 1'b0;
  assign boost_fault_pin_oe          = s_q.fault_od;

endmodule

`default_nettype wire

// *** src/boost_ctrl_pkg.sv ***
package boost_ctrl_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned UV_TIMEOUT_MS     = 110;
  localparam int unsigned UV_TIMEOUT_CYC    = CLK_HZ / 1000 * UV_TIMEOUT_MS;

  // Sync detection: a valid clock lies between 100 kHz and 2222 kHz.
  localparam int unsigned SYNC_MIN_KHZ      = 100;
  localparam int unsigned SYNC_MAX_KHZ      = 2222;
  // Longest allowed period rounds down, shortest rounds up.
  localparam int unsigned SYNC_MAX_PER_CYC  = CLK_HZ / (SYNC_MIN_KHZ * 1000);
  localparam int unsigned SYNC_MIN_PER_CYC  =
    (CLK_HZ + SYNC_MAX_KHZ * 1000 - 1) / (SYNC_MAX_KHZ * 1000);
  localparam int unsigned SYNC_GOOD_EDGES   = 4;

  // Adaptive loop.
  localparam int unsigned NUM_CH            = 6;
  localparam int unsigned TARGET_W          = 10;
  localparam logic [9:0]  TARGET_MAX        = 10'h3ff;
  // 88 percent of full span.
  localparam int unsigned INIT_PCT          = 88;
  localparam logic [9:0]  TARGET_INIT       =
    10'((1023 * INIT_PCT) / 100);
  localparam int unsigned SAMPLE_US         = 10;
  localparam int unsigned SAMPLE_CYC        = CLK_HZ / 1_000_000 * SAMPLE_US;
  localparam int unsigned SOFTSTART_US      = 500;
  localparam int unsigned SOFTSTART_CYC     =
    CLK_HZ / 1_000_000 * SOFTSTART_US;

  // Spread spectrum field reset values.
  localparam logic [1:0]  SPAN_RESET        = 2'h2;
  localparam logic [1:0]  DITHER_RATE_RESET = 2'h0;

  // Span deviation in tenths of a percent, indexed by field.
  function automatic logic [6:0] span_tenths(input logic [1:0] f);
    case (f)
      2'h0:    span_tenths = 7'd33;
      2'h1:    span_tenths = 7'd43;
      2'h2:    span_tenths = 7'd53;
      default: span_tenths = 7'd72;
    endcase
  endfunction

  // Modulation rate in hertz, indexed by field.
  function automatic logic [10:0] rate_hz(input logic [1:0] f);
    case (f)
      2'h0:    rate_hz = 11'd200;
      2'h1:    rate_hz = 11'd500;
      2'h2:    rate_hz = 11'd800;
      default: rate_hz = 11'd1200;
    endcase
  endfunction

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_FAULT = 4'b1000
  } loop_state_t;

endpackage

// *** src/sync_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

// Watches the synchronised select pin for a clock inside the legal band.
module sync_detect (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic reset,
  // Synchronised pin level.
  input  wire logic pin_s,
  // Result.
  output logic      clk_present,
  output logic      rise_pulse
);

  typedef struct packed {
    logic        prev;
    logic [15:0] per;
    logic [2:0]  good;
    logic        present;
    logic        rise;
  } sd_t;

  sd_t s_q, s_d;

  // A period counter checks each rising edge; a stall drops presence.
  always_comb begin
    s_d = s_q;
    s_d.prev = pin_s;
    s_d.rise = 1'b0;
    if (s_q.per < 16'(boost_ctrl_pkg::SYNC_MAX_PER_CYC + 1)) begin
      s_d.per = s_q.per + 16'h1;
    end
    if (pin_s && !s_q.prev) begin
      s_d.rise = 1'b1;
      s_d.per = 16'h0;
      if (s_q.per + 16'h1 >= 16'(boost_ctrl_pkg::SYNC_MIN_PER_CYC) &&
          s_q.per < 16'(boost_ctrl_pkg::SYNC_MAX_PER_CYC)) begin
        if (s_q.good != 3'(boost_ctrl_pkg::SYNC_GOOD_EDGES)) begin
          s_d.good = s_q.good + 3'h1;
        end else begin
          s_d.present = 1'b1;
        end
      end else begin
        s_d.good = 3'h0;
        s_d.present = 1'b0;
      end
    end else if (s_q.per >= 16'(boost_ctrl_pkg::SYNC_MAX_PER_CYC)) begin
      s_d.good = 3'h0;
      s_d.present = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_present = s_q.present;
  assign rise_pulse  = s_q.rise;

endmodule

`default_nettype wire

// *** src/boost_clock_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

// Internal boost clock with triangular dither of the period.
module boost_clock_gen (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Control.
  input  wire logic [15:0] base_period,
  input  wire logic        dither_on,
  input  wire logic [1:0]  span_field,
  input  wire logic [1:0]  rate_field,
  // Output.
  output logic             tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [23:0] mod_cnt;
    logic [7:0]  phase;
    logic        down;
    logic        tick;
  } cg_t;

  cg_t s_q, s_d;
  logic [15:0] full;
  logic [15:0] dev;
  logic [15:0] per;
  logic [23:0] step_len;

  // The triangle phase sweeps the period from base plus span down to base
  // minus span, so the deviation is centred on the resistor frequency.
  always_comb begin
    full = 16'((32'(base_period) *
                32'(boost_ctrl_pkg::span_tenths(span_field))) / 32'd1000);
    dev = 16'((32'(base_period) *
               32'(boost_ctrl_pkg::span_tenths(span_field)) *
               32'(s_q.phase)) / 32'd128000);
    per = dither_on ? base_period + full - dev : base_period;
    // Step length assumes 512 phase steps; the triangle cycle has 510.
    step_len = 24'(boost_ctrl_pkg::CLK_HZ /
                   (32'(boost_ctrl_pkg::rate_hz(rate_field)) * 512));
  end

  // Period counter and triangle phase accumulator.
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt + 16'h1 >= per) begin
      s_d.cnt = 16'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h1;
    end
    if (s_q.mod_cnt + 24'h1 >= step_len) begin
      s_d.mod_cnt = 24'h0;
      if (s_q.down) begin
        s_d.phase = s_q.phase - 8'h1;
        if (s_q.phase == 8'h1) s_d.down = 1'b0;
      end else begin
        s_d.phase = s_q.phase + 8'h1;
        if (s_q.phase == 8'hfe) s_d.down = 1'b1;
      end
    end else begin
      s_d.mod_cnt = s_q.mod_cnt + 24'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

`default_nettype wire

// *** verif/boost_adaptive_sync_control_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// Watches the controller's ports; all checks share the one clock domain.
module boost_ctrl_checker (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       reset,
  // Stimulus seen at the ports.
  input wire logic       overvoltage_low_level,
  input wire logic       overvoltage_high_level,
  input wire logic       undervoltage_level,
  input wire logic       enable_pin,
  input wire logic       bus_enable,
  input wire logic       fault_clear,
  input wire logic       span_write,
  input wire logic [1:0] span_wdata,
  input wire logic       dither_rate_write,
  input wire logic [1:0] dither_rate_wdata,
  // Controller outputs.
  input wire logic       boost_gate,
  input wire logic       sinks_active,
  input wire logic       fault_recovery,
  input wire logic [9:0] boost_target,
  input wire logic       ext_sync_mode,
  input wire logic       dither_enabled,
  input wire logic [1:0] span_field,
  input wire logic [1:0] dither_rate_field,
  input wire logic       boost_overvoltage_low_flag,
  input wire logic       boost_overvoltage_high_flag,
  input wire logic       boost_overcurrent_flag,
  input wire logic       boost_fault_pin_out,
  input wire logic       boost_fault_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Field writes land one edge after the strobe.
  span_write_a:
    assert property (span_write |=> span_field == $past(span_wdata))
    else $error("span field missed a write");
  rate_write_a:
    assert property (dither_rate_write |=>
      dither_rate_field == $past(dither_rate_wdata))
    else $error("rate field missed a write");

  // The loop moves the target one step per sample, never more.
  target_step_a:
    assert property (sinks_active && $past(sinks_active) &&
      boost_target != $past(boost_target) |->
      10'(boost_target - $past(boost_target)) inside {10'h001, 10'h3ff})
    else $error("target moved by more than one step");
  sample_gap_a:
    assert property (sinks_active && $changed(boost_target) |=>
      $stable(boost_target) [*8])
    else $error("target changed twice within a sample");

  // A sustained low overvoltage stops switching and raises its flag.
  ovl_gate_a:
    assert property (overvoltage_low_level [*5] |-> !boost_gate)
    else $error("gate pulsed during low overvoltage");
  ovl_flag_a:
    assert property (sinks_active && overvoltage_low_level [*5] |->
      boost_overvoltage_low_flag)
    else $error("low overvoltage flag not set");

  // High overvoltage raises its flag and the fault state on the same edge.
  ovh_flag_a:
    assert property (sinks_active && overvoltage_high_level [*3] |->
      ##[0:2] boost_overvoltage_high_flag)
    else $error("high overvoltage flag not set");
  ovh_fault_a:
    assert property ($rose(boost_overvoltage_high_flag) && enable_pin |->
      ##[0:2] fault_recovery)
    else $error("no fault recovery after high overvoltage");

  // The overcurrent flag only follows a long undervoltage.
  uv_cause_a:
    assert property ($rose(boost_overcurrent_flag) |->
      $past(undervoltage_level, 4))
    else $error("overcurrent flag without undervoltage");

  // Dither can never run on an external clock.
  sync_dither_a:
    assert property (ext_sync_mode |-> !dither_enabled)
    else $error("dither on in external sync mode");

  // The fault pin only pulls low, and never while the bus owns it.
  pin_release_a:
    assert property (bus_enable [*2] |->
      !boost_fault_pin_oe && !boost_fault_pin_out)
    else $error("fault pin driven while bus enabled");
  pin_drive_a:
    assert property ((!bus_enable && boost_overvoltage_high_flag) [*2] |->
      boost_fault_pin_oe)
    else $error("fault pin not pulled low");

  // A clear with no pending cause empties the flag.
  clear_a:
    assert property ((!overvoltage_high_level) [*4] ##0 fault_clear |=>
      !boost_overvoltage_high_flag)
    else $error("flag survived a clear");
endmodule

bind boost_adaptive_sync_control boost_ctrl_checker chk_u (
  .mclk(mclk), .reset(reset),
  .overvoltage_low_level(overvoltage_low_level),
  .overvoltage_high_level(overvoltage_high_level),
  .undervoltage_level(undervoltage_level), .enable_pin(enable_pin),
  .bus_enable(bus_enable), .fault_clear(fault_clear),
  .span_write(span_write), .span_wdata(span_wdata),
  .dither_rate_write(dither_rate_write),
  .dither_rate_wdata(dither_rate_wdata), .boost_gate(boost_gate),
  .sinks_active(sinks_active), .fault_recovery(fault_recovery),
  .boost_target(boost_target), .ext_sync_mode(ext_sync_mode),
  .dither_enabled(dither_enabled), .span_field(span_field),
  .dither_rate_field(dither_rate_field),
  .boost_overvoltage_low_flag(boost_overvoltage_low_flag),
  .boost_overvoltage_high_flag(boost_overvoltage_high_flag),
  .boost_overcurrent_flag(boost_overcurrent_flag),
  .boost_fault_pin_out(boost_fault_pin_out),
  .boost_fault_pin_oe(boost_fault_pin_oe));

`default_nettype wire

// *** verif/led_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Power stage and strings as the controller sees them.
module led_stage_model #(
  parameter int SYNC_HALF = 20
) (
  // Clock.
  input  wire logic        mclk,
  // Controller outputs.
  input  wire logic [9:0]  boost_target,
  input  wire logic        sinks_active,
  input  wire logic        boost_gate,
  // Scenario controls.
  input  wire logic [59:0] need,
  input  wire logic        sync_run,
  input  wire logic        sync_level,
  // Sense lines and sync source.
  output logic [5:0]       headroom_low,
  output logic             sel_pin = 1'b0,
  output int               gates = 0
);
  int cnt = 0;

  // A sink lacks headroom while the target is under its string's need;
  // idle sinks and grounded outputs also read low, as real pins would.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      headroom_low[i] = !sinks_active || boost_target < need[i*10+:10];
    end
  end

  // Sync source runs 1.2 times the internal rate, else holds a level.
  always @(posedge mclk) begin
    if (sync_run) begin
      cnt <= (cnt == SYNC_HALF - 1) ? 0 : cnt + 1;
      if (cnt == SYNC_HALF - 1) begin
        sel_pin <= !sel_pin;
      end
    end else begin
      sel_pin <= sync_level;
    end
    if (boost_gate) begin
      gates <= gates + 1;
    end
  end
endmodule

`default_nettype wire

// *** verif/boost_adaptive_sync_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module boost_adaptive_sync_control_tb_top;
  // Stimulus.
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        enable_pin = 1'b0;
  logic [5:0]  string_fault = 6'h02;
  logic        ov_low = 1'b0;
  logic        ov_high = 1'b0;
  logic        uv = 1'b0;
  logic        bus_enable = 1'b0;
  logic        fault_clear = 1'b0;
  logic        span_write = 1'b0;
  logic        rate_write = 1'b0;
  logic [1:0]  span_wdata = 2'h0;
  logic [1:0]  rate_wdata = 2'h0;
  logic        sync_run = 1'b0;
  logic        sync_level = 1'b0;
  logic [59:0] need = {40'hffffffffff, 10'h3b6, 10'h352};
  // Observed.
  logic        sel_pin, gate, sinks, frec, ext_mode, dith;
  logic        fl_l, fl_h, fl_oc, pin_out, pin_oe;
  logic [5:0]  headroom_low;
  logic [9:0]  target;
  logic [1:0]  span_f, rate_f;
  int          gates, g0;
  int          fail_count = 0;
  int          num_checks = 0;

  always #12.5 mclk = ~mclk;

  boost_adaptive_sync_control dut_u (
    .mclk(mclk), .reset(reset), .enable_pin(enable_pin),
    .boost_clock_select_pin(sel_pin), .string_count_setting_pin(3'h2),
    .headroom_low(headroom_low), .string_fault(string_fault),
    .overvoltage_low_level(ov_low), .overvoltage_high_level(ov_high),
    .undervoltage_level(uv), .supply_uv(1'b0), .thermal_shutdown(1'b0),
    .bus_enable(bus_enable), .fault_clear(fault_clear),
    .span_write(span_write), .span_wdata(span_wdata),
    .dither_rate_write(rate_write), .dither_rate_wdata(rate_wdata),
    .base_period(16'h0030), .boost_gate(gate), .sinks_active(sinks),
    .fault_recovery(frec), .boost_target(target),
    .ext_sync_mode(ext_mode), .dither_enabled(dith),
    .span_field(span_f), .dither_rate_field(rate_f),
    .boost_overvoltage_low_flag(fl_l), .boost_overvoltage_high_flag(fl_h),
    .boost_overcurrent_flag(fl_oc), .boost_fault_pin_out(pin_out),
    .boost_fault_pin_oe(pin_oe));

  led_stage_model stage_u (
    .mclk(mclk), .boost_target(target), .sinks_active(sinks),
    .boost_gate(gate), .need(need), .sync_run(sync_run),
    .sync_level(sync_level), .headroom_low(headroom_low),
    .sel_pin(sel_pin), .gates(gates));

  // Prints the verdict and stops; also the exit for a hung wait.
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sampling waits 1 ns past the edge so registered outputs have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int i;
    i = 0;
    while (s !== lvl && i < lim) begin
      cyc(1);
      i++;
    end
    if (s !== lvl) begin
      fail_count++;
      $display("[ERR] bounded wait expected %b seen %b", lvl, s);
      complete_run();
    end
  endtask

  task automatic put_fields(input logic [1:0] s, input logic [1:0] r);
    @(posedge mclk);
    span_write <= 1'b1;
    span_wdata <= s;
    rate_write <= 1'b1;
    rate_wdata <= r;
    @(posedge mclk);
    span_write <= 1'b0;
    rate_write <= 1'b0;
    cyc(1);
  endtask

  // Main sequence; the long undervoltage timeout is left to the checker.
  initial begin
    cyc(2);
    @(posedge mclk) reset <= 1'b0;
    cyc(1);
    check("span reset", 16'(span_f), 16'h0002);
    check("rate reset", 16'(rate_f), 16'h0000);
    for (int v = 0; v < 4; v++) begin
      put_fields(2'(v), 2'(3 - v));
      check("span field", 16'(span_f), 16'(v));
      check("rate field", 16'(rate_f), 16'(3 - v));
    end
    put_fields(2'h2, 2'h0);
    @(posedge mclk) enable_pin <= 1'b1;
    cyc(4);
    check("start target", 16'(target), 16'h0384);
    check("sinks at start", 16'(sinks), 16'h0000);
    check("static low dither", 16'(dith), 16'h0000);
    check("no sync at start", 16'(ext_mode), 16'h0000);
    wait_lvl(sinks, 1'b1, 20100);
    // Faulted string 1 and unused outputs must not hold the target up.
    cyc(21000);
    check("settled", 16'(target inside {[849:851]}), 16'h1);
    @(posedge mclk) string_fault <= 6'h00;
    cyc(4400);
    check("raised", 16'(target inside {[858:862]}), 16'h1);
    @(posedge mclk) ov_low <= 1'b1;
    cyc(8);
    g0 = gates;
    check("ovl flag", 16'(fl_l), 16'h0001);
    cyc(200);
    check("ovl gates", 16'(gates - g0), 16'h0000);
    check("ovl sinks", 16'(sinks), 16'h0001);
    @(posedge mclk) ov_low <= 1'b0;
    cyc(200);
    check("resumed", 16'(gates - g0 >= 2), 16'h1);
    @(posedge mclk) uv <= 1'b1;
    cyc(2000);
    @(posedge mclk) uv <= 1'b0;
    cyc(10);
    check("uv flag", 16'(fl_oc), 16'h0000);
    check("uv fault", 16'(frec), 16'h0000);
    @(posedge mclk) sync_run <= 1'b1;
    wait_lvl(ext_mode, 1'b1, 1000);
    check("sync dither", 16'(dith), 16'h0000);
    g0 = gates;
    cyc(400);
    check("sync gates", 16'(gates - g0 inside {[9:11]}), 16'h1);
    @(posedge mclk);
    sync_level <= 1'b1;
    sync_run <= 1'b0;
    wait_lvl(ext_mode, 1'b0, 1000);
    check("lost sync dither", 16'(dith), 16'h0001);
    @(posedge mclk) sync_level <= 1'b0;
    cyc(10);
    check("low dither", 16'(dith), 16'h0000);
    @(posedge mclk) ov_high <= 1'b1;
    cyc(6);
    check("ovh flag", 16'(fl_h), 16'h0001);
    check("ovh fault", 16'(frec), 16'h0001);
    check("pin pulled", 16'({pin_oe, pin_out}), 16'h0002);
    @(posedge mclk) bus_enable <= 1'b1;
    cyc(4);
    check("pin released", 16'(pin_oe), 16'h0000);
    @(posedge mclk) ov_high <= 1'b0;
    cyc(5);
    @(posedge mclk) fault_clear <= 1'b1;
    @(posedge mclk) fault_clear <= 1'b0;
    cyc(2);
    check("cleared", 16'({fl_h, fl_l}), 16'h0000);
    // Low overvoltage latches even in fault state, so enable fall has work.
    @(posedge mclk) ov_low <= 1'b1;
    cyc(6);
    @(posedge mclk) ov_low <= 1'b0;
    cyc(5);
    check("ovl in fault", 16'(fl_l), 16'h0001);
    @(posedge mclk) enable_pin <= 1'b0;
    cyc(6);
    check("enable fall", 16'({fl_h, fl_l, frec}), 16'h0000);
    complete_run();
  end
endmodule

`default_nettype wire
